// ---- design/hemw_defines.svh ----
`ifndef HEMW_DEFINES_SVH
`define HEMW_DEFINES_SVH

// host i/o word indices (byte address = 4 * index)
`define HEMW_HI_H2E 4'h0
`define HEMW_HI_E2H 4'h1
`define HEMW_HI_ADDR_LO 4'h2
`define HEMW_HI_ADDR_HI 4'h3
`define HEMW_HI_DATA0 4'h4
`define HEMW_HI_DATA3 4'h7
`define HEMW_HI_SRC_LO 4'h8
`define HEMW_HI_SRC_HI 4'h9
`define HEMW_HI_MASK_LO 4'ha
`define HEMW_HI_MASK_HI 4'hb
`define HEMW_HI_APPID 4'hc

// controller-only word indices; bit 15 of the byte address selects memory
`define HEMW_EI_H2E 4'h0
`define HEMW_EI_E2H 4'h1
`define HEMW_EI_SRC 4'h2
`define HEMW_EI_MASK 4'h3
`define HEMW_EI_IRQ_EN 4'h4
`define HEMW_EI_R0_BASE 4'h5
`define HEMW_EI_R0_RDLIM 4'h6
`define HEMW_EI_R0_WRLIM 4'h7
`define HEMW_EI_R1_BASE 4'h8
`define HEMW_EI_R1_RDLIM 4'h9
`define HEMW_EI_R1_WRLIM 4'ha
`define HEMW_EC_MEM_BIT 15

// window address fields
`define HEMW_REGION_BIT 15
`define HEMW_XFER_BYTE 2'h0
`define HEMW_XFER_HALF 2'h1
`define HEMW_XFER_WORD 2'h2
`define HEMW_XFER_AUTO 2'h3

// interrupt source and group bit positions
`define HEMW_SRC_WR_BIT 0
`define HEMW_EM_IRQ_BIT 3

// reset values
`define HEMW_BYTE_RST 8'h00
`define HEMW_ADDR_RST 16'h0000
`define HEMW_DATA_RST 32'h0000_0000
`define HEMW_SW_RST 15'h0000
`define HEMW_MASK_RST 16'h0000
`define HEMW_BASE_RST 13'h0000
`define HEMW_LIMIT_RST 14'h0000
`define HEMW_UNMAPPED 32'h0000_0000

`endif

// ---- design/hemw_pkg.sv ----
package hemw_pkg;
	// bus slave sequence: take, answer, drop ack
	typedef enum logic [1:0] {bus_idle, bus_resp, bus_hold} hemw_bus_st_t;
	// window transfer size code
	typedef logic [1:0] hemw_xfer_t;
endpackage

// ---- design/hemw_mem_if.sv ----
`timescale 1ns/1ps
interface hemw_mem_if;
	// port a: host window, port b: controller
	logic [12:0] a_addr;
	logic a_we;
	logic [3:0] a_be;
	logic [31:0] a_wdata;
	logic [31:0] a_rdata;
	logic [12:0] b_addr;
	logic b_we;
	logic [3:0] b_be;
	logic [31:0] b_wdata;
	logic [31:0] b_rdata;
	modport ctrl (output a_addr, a_we, a_be, a_wdata, b_addr, b_we, b_be, b_wdata,
		input a_rdata, b_rdata);
	modport mem (input a_addr, a_we, a_be, a_wdata, b_addr, b_we, b_be, b_wdata,
		output a_rdata, b_rdata);
endinterface

// ---- design/hemw_dmem.sv ----
`timescale 1ns/1ps
// controller data memory, two synchronous ports with byte lanes
module hemw_dmem (
	// clock
	input wire logic clk,
	// both access ports
	hemw_mem_if.mem port
);
	// 8192 double words; port b writes last on a same-lane collision
	logic [31:0] mem_q [0:8191];
	logic [31:0] a_rd_q;
	logic [31:0] b_rd_q;

	// one lane per byte; a single process owns the array so it has one driver
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (port.a_we && port.a_be[i])
			begin
				mem_q[port.a_addr][8*i +: 8] <= port.a_wdata[8*i +: 8];
			end
			if (port.b_we && port.b_be[i])
			begin
				mem_q[port.b_addr][8*i +: 8] <= port.b_wdata[8*i +: 8];
			end
		end
	end

	// read data one cycle after the address
	always_ff @(posedge clk)
	begin
		a_rd_q <= mem_q[port.a_addr];
		b_rd_q <= mem_q[port.b_addr];
	end

	assign port.a_rdata = a_rd_q;
	assign port.b_rdata = b_rd_q;
endmodule // hemw_dmem

// ---- design/hemw_regions.sv ----
`timescale 1ns/1ps
// region base and limit check for the host window
module hemw_regions (
	// window position
	input wire logic region,
	input wire logic [12:0] offset,
	// region settings
	input wire logic [12:0] base0,
	input wire logic [13:0] rdlim0,
	input wire logic [13:0] wrlim0,
	input wire logic [12:0] base1,
	input wire logic [13:0] rdlim1,
	input wire logic [13:0] wrlim1,
	// result
	output logic [12:0] phys,
	output logic rd_ok,
	output logic wr_ok
);
	logic [12:0] base_a [0:1];
	logic [13:0] rd_a [0:1];
	logic [13:0] wr_a [0:1];
	logic [12:0] phys_a [0:1];
	logic [1:0] rd_ok_a;
	logic [1:0] wr_ok_a;

	assign base_a[0] = base0;
	assign base_a[1] = base1;
	assign rd_a[0] = rdlim0;
	assign rd_a[1] = rdlim1;
	assign wr_a[0] = wrlim0;
	assign wr_a[1] = wrlim1;

	// limits are independent; a zero limit closes that direction
	for (genvar g = 0; g < 2; g++)
	begin : g_region
		// base plus offset wraps in the memory, so a region may span all of it
		assign phys_a[g] = 13'(base_a[g] + offset);
		assign rd_ok_a[g] = {1'b0, offset} < rd_a[g];
		assign wr_ok_a[g] = {1'b0, offset} < wr_a[g];
	end

	// region bit of the window address picks one
	assign phys = phys_a[region];
	assign rd_ok = rd_ok_a[region];
	assign wr_ok = wr_ok_a[region];
endmodule // hemw_regions

// ---- design/hemw_top.sv ----
`timescale 1ns/1ps
`include "hemw_defines.svh"
// Summary of operation
// - system reset returns every register but bus state and read data to default
// - twelve host byte registers plus identifier
// - controller-only settings unreachable from host
// - host mailbox write raises masked controller event
// - controller event is a source group bit
// - controller mailbox write drives high serirq level
// - enabled software bits or mailbox write raise event
// - software event active low toward serirq
// - mailbox host event high after controller write
// - software host event is inverse of serirq
// - both host events go to runtime logic
// - data bytes read and write memory window
// - window uses direct port, no firmware help
// - byte, half and word transfer sizes
// - auto-increment streams through consecutive words
// - two regions with base and limits
// - independent limits, zero read limit is write-only
// - regions may span whole memory
// - identifier register returns last value written
// - two-bit code selects size and trigger byte
// - auto mode steps address on top byte
// - writing one clears controller mailbox bit
// - reader clears the matching mailbox interrupt
module hemw_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic system_reset_n,
	// host i/o space, classic wishbone
	input wire logic host_cyc,
	input wire logic host_stb,
	input wire logic host_we,
	input wire logic [5:0] host_adr,
	input wire logic [3:0] host_sel,
	input wire logic [31:0] host_dat_w,
	output logic host_ack,
	output logic [31:0] host_dat_r,
	// controller space, classic wishbone
	input wire logic ec_cyc,
	input wire logic ec_stb,
	input wire logic ec_we,
	input wire logic [15:0] ec_adr,
	input wire logic [3:0] ec_sel,
	input wire logic [31:0] ec_dat_w,
	output logic ec_ack,
	output logic [31:0] ec_dat_r,
	// events
	output logic serirq_mbox_level,
	output logic serirq_sw_level_n,
	output logic mailbox_host_event,
	output logic sw_host_event,
	output logic [7:0] ec_irq_source_group
);
	// trigger lanes per size code; one decode for loads, one for stores
	function automatic logic [3:0] hemw_lanes(input logic [1:0] xfer, input logic [1:0] b,
		input logic wr);
		logic [3:0] l;
		l = 4'h0;
		if (xfer == `HEMW_XFER_BYTE)
		begin
			l = 4'(4'h1 << b);
		end
		else if (xfer == `HEMW_XFER_HALF)
		begin
			// loads fire on the low byte of a half, stores on the high one
			if (!wr && b == 2'h0) l = 4'h3;
			else if (!wr && b == 2'h2) l = 4'hc;
			else if (wr && b == 2'h1) l = 4'h3;
			else if (wr && b == 2'h3) l = 4'hc;
		end
		else
		begin
			if (!wr && b == 2'h0) l = 4'hf;
			else if (wr && b == 2'h3) l = 4'hf;
		end
		return l;
	endfunction

	// memory port bundle
	hemw_mem_if mem_bus();

	// bus state
	hemw_pkg::hemw_bus_st_t hst_q, hst_d, est_q, est_d;
	logic host_ack_q, host_ack_d, ec_ack_q, ec_ack_d;
	logic [31:0] host_dat_q, host_dat_d, ec_dat_q, ec_dat_d;
	// mailboxes and their flags
	logic [7:0] h2e_q, h2e_d, e2h_q, e2h_d;
	logic h2e_irq_q, h2e_irq_d; // host wrote, controller not yet read
	logic e2h_evt_q, e2h_evt_d; // controller wrote, host not yet read
	logic wr_flag_q, wr_flag_d; // mailbox_written_flag
	logic [14:0] sw_q, sw_d; // sw_event_bits
	logic [15:0] mask_q, mask_d; // bit 0 write enable, above sw enables
	logic ec_irq_en_q, ec_irq_en_d;
	// window
	logic [15:0] addr_q, addr_d;
	logic [31:0] data_q, data_d;
	logic [7:0] app_q, app_d;
	// regions
	logic [12:0] base_q [0:1];
	logic [12:0] base_d [0:1];
	logic [13:0] rdlim_q [0:1];
	logic [13:0] rdlim_d [0:1];
	logic [13:0] wrlim_q [0:1];
	logic [13:0] wrlim_d [0:1];
	// event outputs
	logic mbox_evt_q, mbox_evt_d, sw_evt_q, sw_evt_d;
	logic [7:0] group_q, group_d;

	// decode helpers
	logic [3:0] h_idx, e_idx;
	logic [1:0] h_byte;
	logic h_req, e_req, h_is_data, e_is_mem;
	logic h_act, e_act, h_w, h_r, e_w, e_r;
	logic [3:0] h_rd_lanes, h_wr_lanes;
	logic [31:0] h_merge;
	logic [12:0] win_phys;
	logic win_rd_ok, win_wr_ok;

	hemw_dmem u_mem (
		.clk(clk),
		.port(mem_bus.mem)
	);

	// window offset and region, checked against controller-only limits
	hemw_regions u_regions (
		.region(addr_q[`HEMW_REGION_BIT]),
		.offset(addr_q[14:2]),
		.base0(base_q[0]),
		.rdlim0(rdlim_q[0]),
		.wrlim0(wrlim_q[0]),
		.base1(base_q[1]),
		.rdlim1(rdlim_q[1]),
		.wrlim1(wrlim_q[1]),
		.phys(win_phys),
		.rd_ok(win_rd_ok),
		.wr_ok(win_wr_ok)
	);

	// request decode; register actions happen in the answer cycle while request is held, memory stores in the take cycle
	assign h_idx = host_adr[5:2];
	assign e_idx = ec_adr[5:2];
	assign h_byte = h_idx[1:0];
	assign h_is_data = h_idx >= `HEMW_HI_DATA0 && h_idx <= `HEMW_HI_DATA3;
	assign e_is_mem = ec_adr[`HEMW_EC_MEM_BIT];
	assign h_req = host_cyc && host_stb && hst_q == hemw_pkg::bus_idle;
	assign e_req = ec_cyc && ec_stb && est_q == hemw_pkg::bus_idle;
	assign h_act = host_cyc && host_stb && hst_q == hemw_pkg::bus_resp;
	assign e_act = ec_cyc && ec_stb && est_q == hemw_pkg::bus_resp;
	assign h_w = h_act && host_we && host_sel[0];
	assign h_r = h_act && !host_we;
	assign e_w = e_act && ec_we && ec_sel[0] && !e_is_mem;
	assign e_r = e_act && !ec_we && !e_is_mem;
	assign h_rd_lanes = hemw_lanes(addr_q[1:0], h_byte, 1'b0);
	assign h_wr_lanes = hemw_lanes(addr_q[1:0], h_byte, 1'b1);

	// memory ports: the window runs with no controller involvement
	always_comb
	begin
		h_merge = data_q;
		h_merge[8*h_byte +: 8] = host_dat_w[7:0];
		mem_bus.a_addr = win_phys;
		// store beyond the write limit never reaches memory
		mem_bus.a_we = h_req && host_we && host_sel[0] && h_is_data && win_wr_ok;
		mem_bus.a_be = h_wr_lanes;
		mem_bus.a_wdata = h_merge;
		mem_bus.b_addr = ec_adr[14:2];
		mem_bus.b_we = e_req && ec_we && e_is_mem;
		mem_bus.b_be = ec_sel;
		mem_bus.b_wdata = ec_dat_w;
	end

	// bus sequencing for both slaves
	always_comb
	begin
		hst_d = hst_q;
		est_d = est_q;
		case (hst_q)
			hemw_pkg::bus_idle: if (h_req) hst_d = hemw_pkg::bus_resp;
			hemw_pkg::bus_resp: hst_d = hemw_pkg::bus_hold;
			default: hst_d = hemw_pkg::bus_idle;
		endcase
		case (est_q)
			hemw_pkg::bus_idle: if (e_req) est_d = hemw_pkg::bus_resp;
			hemw_pkg::bus_resp: est_d = hemw_pkg::bus_hold;
			default: est_d = hemw_pkg::bus_idle;
		endcase
		host_ack_d = hst_q == hemw_pkg::bus_resp;
		ec_ack_d = est_q == hemw_pkg::bus_resp;
	end

	// shared register next values
	always_comb
	begin
		h2e_d = h2e_q;
		e2h_d = e2h_q;
		h2e_irq_d = h2e_irq_q;
		e2h_evt_d = e2h_evt_q;
		wr_flag_d = wr_flag_q;
		sw_d = sw_q;
		mask_d = mask_q;
		ec_irq_en_d = ec_irq_en_q;
		addr_d = addr_q;
		data_d = data_q;
		app_d = app_q;
		base_d = base_q;
		rdlim_d = rdlim_q;
		wrlim_d = wrlim_q;
		host_dat_d = host_dat_q;
		ec_dat_d = ec_dat_q;
		// clears first, so a set in the same cycle wins
		if (e_r && e_idx == `HEMW_EI_H2E) h2e_irq_d = 1'b0;
		if (h_r && h_idx == `HEMW_HI_E2H) e2h_evt_d = 1'b0;
		if (h_w && h_idx == `HEMW_HI_E2H) e2h_d = e2h_d & ~host_dat_w[7:0];
		if (e_w && e_idx == `HEMW_EI_H2E) h2e_d = h2e_d & ~ec_dat_w[7:0];
		if (h_w && h_idx == `HEMW_HI_SRC_LO)
		begin
			wr_flag_d = wr_flag_q & ~host_dat_w[`HEMW_SRC_WR_BIT];
			sw_d[6:0] = sw_q[6:0] & ~host_dat_w[7:1];
		end
		if (h_w && h_idx == `HEMW_HI_SRC_HI) sw_d[14:7] = sw_q[14:7] & ~host_dat_w[7:0];
		if (e_w && e_idx == `HEMW_EI_SRC)
		begin
			// controller writes one to clear the flag and to set software bits
			wr_flag_d = wr_flag_d & ~ec_dat_w[`HEMW_SRC_WR_BIT];
			sw_d = sw_d | ec_dat_w[15:1];
		end
		// host side writes
		if (h_w && h_idx == `HEMW_HI_H2E)
		begin
			h2e_d = host_dat_w[7:0];
			h2e_irq_d = 1'b1;
		end
		if (h_w && h_idx == `HEMW_HI_ADDR_LO) addr_d[7:0] = host_dat_w[7:0];
		if (h_w && h_idx == `HEMW_HI_ADDR_HI) addr_d[15:8] = host_dat_w[7:0];
		if (h_w && h_idx == `HEMW_HI_MASK_LO) mask_d[7:0] = host_dat_w[7:0];
		if (h_w && h_idx == `HEMW_HI_MASK_HI) mask_d[15:8] = host_dat_w[7:0];
		if (h_w && h_idx == `HEMW_HI_APPID) app_d = host_dat_w[7:0];
		if (h_w && h_is_data) data_d[8*h_byte +: 8] = host_dat_w[7:0];
		// loads from memory; a closed region loads zero
		if (h_r && h_is_data)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (h_rd_lanes[i])
				begin
					data_d[8*i +: 8] = win_rd_ok ? mem_bus.a_rdata[8*i +: 8] : 8'h00;
				end
			end
		end
		// top data byte advances by one double word in auto mode
		if (h_act && h_is_data && h_byte == 2'h3 && addr_q[1:0] == `HEMW_XFER_AUTO
			&& (host_sel[0] || !host_we))
		begin
			addr_d[14:2] = 13'(addr_q[14:2] + 13'h0001);
		end
		// controller side writes
		if (e_w && e_idx == `HEMW_EI_E2H)
		begin
			e2h_d = ec_dat_w[7:0];
			e2h_evt_d = 1'b1;
			wr_flag_d = 1'b1;
		end
		if (e_w && e_idx == `HEMW_EI_MASK) mask_d = ec_dat_w[15:0];
		if (e_w && e_idx == `HEMW_EI_IRQ_EN) ec_irq_en_d = ec_dat_w[0];
		// region settings live only in controller space
		if (e_w && e_idx == `HEMW_EI_R0_BASE) base_d[0] = ec_dat_w[12:0];
		if (e_w && e_idx == `HEMW_EI_R0_RDLIM) rdlim_d[0] = ec_dat_w[13:0];
		if (e_w && e_idx == `HEMW_EI_R0_WRLIM) wrlim_d[0] = ec_dat_w[13:0];
		if (e_w && e_idx == `HEMW_EI_R1_BASE) base_d[1] = ec_dat_w[12:0];
		if (e_w && e_idx == `HEMW_EI_R1_RDLIM) rdlim_d[1] = ec_dat_w[13:0];
		if (e_w && e_idx == `HEMW_EI_R1_WRLIM) wrlim_d[1] = ec_dat_w[13:0];
		// host read answer, taken after any load
		if (h_act)
		begin
			if (h_idx == `HEMW_HI_H2E) host_dat_d = {24'h0, h2e_q};
			else if (h_idx == `HEMW_HI_E2H) host_dat_d = {24'h0, e2h_q};
			else if (h_idx == `HEMW_HI_ADDR_LO) host_dat_d = {24'h0, addr_q[7:0]};
			else if (h_idx == `HEMW_HI_ADDR_HI) host_dat_d = {24'h0, addr_q[15:8]};
			else if (h_is_data) host_dat_d = {24'h0, data_d[8*h_byte +: 8]};
			else if (h_idx == `HEMW_HI_SRC_LO) host_dat_d = {24'h0, sw_q[6:0], wr_flag_q};
			else if (h_idx == `HEMW_HI_SRC_HI) host_dat_d = {24'h0, sw_q[14:7]};
			else if (h_idx == `HEMW_HI_MASK_LO) host_dat_d = {24'h0, mask_q[7:0]};
			else if (h_idx == `HEMW_HI_MASK_HI) host_dat_d = {24'h0, mask_q[15:8]};
			else if (h_idx == `HEMW_HI_APPID) host_dat_d = {24'h0, app_q};
			else host_dat_d = `HEMW_UNMAPPED;
		end
		// controller read answer
		if (e_act)
		begin
			if (e_is_mem) ec_dat_d = mem_bus.b_rdata;
			else if (e_idx == `HEMW_EI_H2E) ec_dat_d = {24'h0, h2e_q};
			else if (e_idx == `HEMW_EI_E2H) ec_dat_d = {24'h0, e2h_q};
			else if (e_idx == `HEMW_EI_SRC) ec_dat_d = {16'h0, sw_q, wr_flag_q};
			else if (e_idx == `HEMW_EI_MASK) ec_dat_d = {16'h0, mask_q};
			else if (e_idx == `HEMW_EI_IRQ_EN) ec_dat_d = {31'h0, ec_irq_en_q};
			else if (e_idx == `HEMW_EI_R0_BASE) ec_dat_d = {19'h0, base_q[0]};
			else if (e_idx == `HEMW_EI_R0_RDLIM) ec_dat_d = {18'h0, rdlim_q[0]};
			else if (e_idx == `HEMW_EI_R0_WRLIM) ec_dat_d = {18'h0, wrlim_q[0]};
			else if (e_idx == `HEMW_EI_R1_BASE) ec_dat_d = {19'h0, base_q[1]};
			else if (e_idx == `HEMW_EI_R1_RDLIM) ec_dat_d = {18'h0, rdlim_q[1]};
			else if (e_idx == `HEMW_EI_R1_WRLIM) ec_dat_d = {18'h0, wrlim_q[1]};
			else ec_dat_d = `HEMW_UNMAPPED;
		end
		// system reset clears the interface but not memory contents
		if (!system_reset_n)
		begin
			h2e_d = `HEMW_BYTE_RST;
			e2h_d = `HEMW_BYTE_RST;
			h2e_irq_d = 1'b0;
			e2h_evt_d = 1'b0;
			wr_flag_d = 1'b0;
			sw_d = `HEMW_SW_RST;
			mask_d = `HEMW_MASK_RST;
			ec_irq_en_d = 1'b0;
			addr_d = `HEMW_ADDR_RST;
			data_d = `HEMW_DATA_RST;
			app_d = `HEMW_BYTE_RST;
			for (int r = 0; r < 2; r++)
			begin
				base_d[r] = `HEMW_BASE_RST;
				rdlim_d[r] = `HEMW_LIMIT_RST;
				wrlim_d[r] = `HEMW_LIMIT_RST;
			end
		end
	end

	// event levels, taken from the next register values
	always_comb
	begin
		mbox_evt_d = e2h_evt_d;
		sw_evt_d = |(sw_d & mask_d[15:1]) || (wr_flag_d && mask_d[0]);
		group_d = 8'h00;
		group_d[`HEMW_EM_IRQ_BIT] = h2e_irq_d && ec_irq_en_d;
	end

	// all state registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hst_q <= hemw_pkg::bus_idle;
			est_q <= hemw_pkg::bus_idle;
			host_ack_q <= 1'b0;
			ec_ack_q <= 1'b0;
			host_dat_q <= `HEMW_DATA_RST;
			ec_dat_q <= `HEMW_DATA_RST;
			h2e_q <= `HEMW_BYTE_RST;
			e2h_q <= `HEMW_BYTE_RST;
			h2e_irq_q <= 1'b0;
			e2h_evt_q <= 1'b0;
			wr_flag_q <= 1'b0;
			sw_q <= `HEMW_SW_RST;
			mask_q <= `HEMW_MASK_RST;
			ec_irq_en_q <= 1'b0;
			addr_q <= `HEMW_ADDR_RST;
			data_q <= `HEMW_DATA_RST;
			app_q <= `HEMW_BYTE_RST;
			base_q <= '{`HEMW_BASE_RST, `HEMW_BASE_RST};
			rdlim_q <= '{`HEMW_LIMIT_RST, `HEMW_LIMIT_RST};
			wrlim_q <= '{`HEMW_LIMIT_RST, `HEMW_LIMIT_RST};
			mbox_evt_q <= 1'b0;
			sw_evt_q <= 1'b0;
			group_q <= 8'h00;
		end
		else
		begin
			hst_q <= hst_d;
			est_q <= est_d;
			host_ack_q <= host_ack_d;
			ec_ack_q <= ec_ack_d;
			host_dat_q <= host_dat_d;
			ec_dat_q <= ec_dat_d;
			h2e_q <= h2e_d;
			e2h_q <= e2h_d;
			h2e_irq_q <= h2e_irq_d;
			e2h_evt_q <= e2h_evt_d;
			wr_flag_q <= wr_flag_d;
			sw_q <= sw_d;
			mask_q <= mask_d;
			ec_irq_en_q <= ec_irq_en_d;
			addr_q <= addr_d;
			data_q <= data_d;
			app_q <= app_d;
			base_q <= base_d;
			rdlim_q <= rdlim_d;
			wrlim_q <= wrlim_d;
			mbox_evt_q <= mbox_evt_d;
			sw_evt_q <= sw_evt_d;
			group_q <= group_d;
		end
	end

	// outputs straight from flops
	assign host_ack = host_ack_q;
	assign host_dat_r = host_dat_q;
	assign ec_ack = ec_ack_q;
	assign ec_dat_r = ec_dat_q;
	assign serirq_mbox_level = mbox_evt_q;
	assign serirq_sw_level_n = ~sw_evt_q;
	assign mailbox_host_event = mbox_evt_q;
	assign sw_host_event = sw_evt_q;
	assign ec_irq_source_group = group_q;
endmodule // hemw_top

// ---- bench/hemw_top_assertions.sv ----
`timescale 1ns/1ps
// port-level checks on the host/controller mailbox and memory window
module hemw_top_assertions (
	// clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic system_reset_n,
	// host bus
	input wire logic host_cyc,
	input wire logic host_stb,
	input wire logic host_we,
	input wire logic [5:0] host_adr,
	input wire logic host_ack,
	input wire logic [31:0] host_dat_r,
	// controller bus
	input wire logic ec_cyc,
	input wire logic ec_stb,
	input wire logic ec_we,
	input wire logic [15:0] ec_adr,
	input wire logic [3:0] ec_sel,
	input wire logic ec_ack,
	// events
	input wire logic serirq_mbox_level,
	input wire logic serirq_sw_level_n,
	input wire logic mailbox_host_event,
	input wire logic sw_host_event,
	input wire logic [7:0] ec_irq_source_group
);
	// single domain, so one clock and one disable for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// window traffic needs no controller action, answer is fixed
	host_lat_a: assert property ($rose(host_cyc && host_stb) |->
		!host_ack ##1 !host_ack ##1 host_ack) else $error("host ack not two cycles after take");
	ack_pulse_a: assert property (host_ack |=> !host_ack)
		else $error("host ack longer than one cycle");
	ec_lat_a: assert property ($rose(ec_cyc && ec_stb) |-> ##2 ec_ack)
		else $error("controller ack late");
	mbox_same_a: assert property (mailbox_host_event == serirq_mbox_level)
		else $error("mailbox event and serirq level differ");
	sw_inv_a: assert property (serirq_sw_level_n == !sw_host_event)
		else $error("serirq software level not inverse of event");
	grp_bit_a: assert property (ec_irq_source_group[7:4] == 4'h0 &&
		ec_irq_source_group[2:0] == 3'h0) else $error("stray source group bit");
	byte_wide_a: assert property (host_dat_r[31:8] == 24'h000000)
		else $error("host read data wider than a byte");
	// controller message store raises the host level shortly after
	mbox_set_a: assert property (ec_ack && ec_we && ec_sel[0] && !ec_adr[15] &&
		ec_adr[5:2] == 4'h1 && system_reset_n |-> ##[1:2] mailbox_host_event)
		else $error("mailbox event missing after controller write");
	mbox_clr_a: assert property (host_ack && !host_we && host_adr[5:2] == 4'h1 |->
		##[1:2] !mailbox_host_event) else $error("host read left mailbox event up");
	sysrst_a: assert property (!system_reset_n |-> ##2 (!mailbox_host_event &&
		!sw_host_event && ec_irq_source_group == 8'h00)) else $error("events survive reset");
endmodule // hemw_top_assertions

bind hemw_top hemw_top_assertions i_hemw_top_assertions (.clk, .rst, .system_reset_n,
	.host_cyc, .host_stb, .host_we, .host_adr, .host_ack, .host_dat_r, .ec_cyc, .ec_stb,
	.ec_we, .ec_adr, .ec_sel, .ec_ack, .serirq_mbox_level, .serirq_sw_level_n,
	.mailbox_host_event, .sw_host_event, .ec_irq_source_group);

// ---- bench/hemw_wb_master.sv ----
`timescale 1ns/1ps
// classic wishbone master standing in for the host or the controller
module hemw_wb_master #(parameter int AW = 6) (
	// clock
	input wire logic clk,
	// request
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [AW-1:0] adr,
	output logic [3:0] sel,
	output logic [31:0] dat_w,
	// answer
	input wire logic ack,
	input wire logic [31:0] dat_r
);
	// idle bus at time zero
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		sel = 4'h0;
		dat_w = 32'h0;
	end

	// one transfer, entered at a rising edge; bench timeout guards a missing ack
	task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
		output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_w <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_r;
		// released address and data show the inverse, not a stale copy
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		adr <= ~a;
		dat_w <= ~d;
		@(posedge clk);
	endtask
endmodule // hemw_wb_master

// ---- bench/hemw_top_tb_top.sv ----
`timescale 1ns/1ps
// table of bus transfers, then resets by hand
module hemw_top_tb_top;
	// kind: 0 host rd, 1 host wr, 2 ec rd, 3 ec wr; d is write or expected data
	typedef struct packed {logic [1:0] k; logic [15:0] a; logic [31:0] d; logic [2:0] v;} hemw_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic srst_n = 1'b1;
	logic h_cyc, h_stb, h_we, h_ack, e_cyc, e_stb, e_we, e_ack;
	logic [5:0] h_adr;
	logic [15:0] e_adr;
	logic [3:0] h_sel, e_sel;
	logic [31:0] h_dw, h_dr, e_dw, e_dr;
	logic mbox_lv, sw_lv_n, mbox_ev, sw_ev;
	logic [7:0] grp;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// v holds expected {mailbox event, software event, group bit}
	hemw_row_t rows [0:62] = '{
		'{2'h0,16'h00,32'h0,3'h0}, '{2'h0,16'h20,32'h0,3'h0},
		'{2'h2,16'h18,32'h0,3'h0}, '{2'h1,16'h30,32'h5a,3'h0},
		'{2'h0,16'h30,32'h5a,3'h0}, '{2'h1,16'h34,32'h77,3'h0},
		'{2'h0,16'h34,32'h0,3'h0}, '{2'h0,16'h3c,32'h0,3'h0},
		'{2'h3,16'h14,32'h10,3'h0}, '{2'h3,16'h18,32'h20,3'h0},
		'{2'h3,16'h1c,32'h20,3'h0}, '{2'h3,16'h20,32'h100,3'h0},
		'{2'h3,16'h28,32'h4,3'h0}, '{2'h1,16'h08,32'h0e,3'h0},
		'{2'h1,16'h10,32'h11,3'h0}, '{2'h1,16'h14,32'h22,3'h0},
		'{2'h1,16'h18,32'h33,3'h0}, '{2'h1,16'h1c,32'h44,3'h0},
		'{2'h2,16'h804c,32'h44332211,3'h0},
		'{2'h3,16'h804c,32'ha1b2c3d4,3'h0}, '{2'h0,16'h10,32'hd4,3'h0},
		'{2'h3,16'h804c,32'h0,3'h0}, '{2'h0,16'h14,32'hc3,3'h0},
		'{2'h1,16'h08,32'h0c,3'h0}, '{2'h1,16'h18,32'h77,3'h0},
		'{2'h2,16'h804c,32'h770000,3'h0}, '{2'h1,16'h08,32'h0d,3'h0},
		'{2'h1,16'h10,32'h55,3'h0}, '{2'h1,16'h14,32'h66,3'h0},
		'{2'h2,16'h804c,32'h776655,3'h0}, '{2'h0,16'h18,32'h77,3'h0},
		'{2'h1,16'h08,32'h0f,3'h0}, '{2'h1,16'h10,32'h01,3'h0},
		'{2'h1,16'h14,32'h02,3'h0}, '{2'h1,16'h18,32'h03,3'h0},
		'{2'h1,16'h1c,32'h04,3'h0}, '{2'h1,16'h1c,32'h99,3'h0},
		'{2'h0,16'h08,32'h17,3'h0}, '{2'h2,16'h804c,32'h04030201,3'h0},
		'{2'h2,16'h8050,32'h99030201,3'h0}, '{2'h3,16'h80c0,32'h12345678,3'h0},
		'{2'h1,16'h08,32'h82,3'h0}, '{2'h1,16'h1c,32'hee,3'h0},
		'{2'h0,16'h10,32'h0,3'h0}, '{2'h2,16'h80c0,32'h12345678,3'h0},
		'{2'h3,16'h8404,32'hcafef00d,3'h0}, '{2'h1,16'h08,32'h06,3'h0},
		'{2'h1,16'h0c,32'h80,3'h0}, '{2'h0,16'h10,32'h0,3'h0},
		'{2'h1,16'h1c,32'hab,3'h0}, '{2'h2,16'h8404,32'hab000000,3'h0},
		'{2'h1,16'h00,32'h3c,3'h0}, '{2'h3,16'h10,32'h1,3'h1},
		'{2'h2,16'h00,32'h3c,3'h0}, '{2'h3,16'h04,32'ha5,3'h4},
		'{2'h0,16'h20,32'h01,3'h4}, '{2'h3,16'h0c,32'h03,3'h6},
		'{2'h0,16'h04,32'ha5,3'h2}, '{2'h1,16'h04,32'h0f,3'h2},
		'{2'h0,16'h04,32'ha0,3'h2}, '{2'h1,16'h20,32'h01,3'h0},
		'{2'h3,16'h08,32'h02,3'h2}, '{2'h0,16'h20,32'h02,3'h2}
	};

	hemw_top i_hemw_top (.clk(clk), .rst(rst), .system_reset_n(srst_n), .host_cyc(h_cyc),
		.host_stb(h_stb), .host_we(h_we), .host_adr(h_adr), .host_sel(h_sel),
		.host_dat_w(h_dw), .host_ack(h_ack), .host_dat_r(h_dr), .ec_cyc(e_cyc),
		.ec_stb(e_stb), .ec_we(e_we), .ec_adr(e_adr), .ec_sel(e_sel), .ec_dat_w(e_dw),
		.ec_ack(e_ack), .ec_dat_r(e_dr), .serirq_mbox_level(mbox_lv),
		.serirq_sw_level_n(sw_lv_n), .mailbox_host_event(mbox_ev),
		.sw_host_event(sw_ev), .ec_irq_source_group(grp));
	hemw_wb_master #(.AW(6)) i_hemw_wb_master_host (.clk(clk), .cyc(h_cyc), .stb(h_stb),
		.we(h_we), .adr(h_adr), .sel(h_sel), .dat_w(h_dw), .ack(h_ack), .dat_r(h_dr));
	hemw_wb_master #(.AW(16)) i_hemw_wb_master_ec (.clk(clk), .cyc(e_cyc), .stb(e_stb),
		.we(e_we), .adr(e_adr), .sel(e_sel), .dat_w(e_dw), .ack(e_ack), .dat_r(e_dr));

	// 25 ns clock
	initial
	begin
		forever
			#12.5 clk = ~clk;
	end

	// a hang ends the run as a failure
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_count++;
			results();
		end
	end

	task automatic miss(input logic [31:0] g, input logic [31:0] x);
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
		err_count++;
	endtask

	task automatic chk_dat(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
			miss(g, x);
	endtask

	// events settle after the edge that follows the answer
	task automatic chk_ev(input logic [2:0] x);
		#1;
		n_compared++;
		if ({mbox_ev, sw_ev, grp[3]} !== x)
			miss({29'h0, mbox_ev, sw_ev, grp[3]}, {29'h0, x});
		@(posedge clk);
	endtask

	task automatic results();
		$display("mismatches %0d, comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// table first, then system reset and asynchronous reset
	initial
	begin
		hemw_row_t r;
		logic [31:0] q;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i])
		begin
			r = rows[i];
			if (r.k[1])
				i_hemw_wb_master_ec.xfer(r.k[0], r.a, r.d, q);
			else
				i_hemw_wb_master_host.xfer(r.k[0], r.a[5:0], r.d, q);
			if (!r.k[0])
				chk_dat(q, r.d);
			chk_ev(r.v);
		end
		srst_n <= 1'b0;
		repeat (2) @(posedge clk);
		srst_n <= 1'b1;
		chk_ev(3'h0);
		i_hemw_wb_master_host.xfer(1'b0, 6'h30, 32'h0, q);
		chk_dat(q, 32'h0);
		i_hemw_wb_master_ec.xfer(1'b0, 16'h0014, 32'h0, q);
		chk_dat(q, 32'h0);
		rst <= 1'b1;
		#1;
		chk_dat({30'h0, mbox_lv, sw_lv_n}, 32'h1);
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		results();
	end
endmodule // hemw_top_tb_top
